// ===== hdl/rlc_field_decode.sv
// Field codes to analog setting values
`timescale 1ns/10ps
module rlc_field_decode
    import rlc_pkg::*;
(
    rlc_cfg_if.dec cfg
);
    //////////////////////////////////////////////////////////////
    // Deemphasis level from the full code, style bit included
    // level decode
    always_comb begin
        cfg.de_ok = 1'b1;
        case (cfg.deemph)
            DE_0DB:  cfg.de_tenths = DB_0;
            DE_3P5:  cfg.de_tenths = DB_3P5;
            DE_6DB:  cfg.de_tenths = DB_6;
            DE_9DB:  cfg.de_tenths = DB_9;
            DE_12DB: cfg.de_tenths = DB_12;
            default: begin
                // Unlisted codes, reserved C0h among them
                cfg.de_tenths = DB_0;
                cfg.de_ok     = 1'b0;
            end
        endcase
    end

    //////////////////////////////////////////////////////////////
    // Idle thresholds from the two code fields
    // threshold map
    always_comb begin
        case (cfg.idle_thr[3:2])
            2'h1:    cfg.deas_mv = MV_150;
            2'h2:    cfg.deas_mv = MV_170;
            2'h3:    cfg.deas_mv = MV_190;
            default: cfg.deas_mv = MV_110;
        endcase
        case (cfg.idle_thr[1:0])
            2'h1:    cfg.as_mv = MV_110;
            2'h2:    cfg.as_mv = MV_130;
            2'h3:    cfg.as_mv = MV_150;
            default: cfg.as_mv = MV_70;
        endcase
    end

    //////////////////////////////////////////////////////////////
    // Output swing
    // swing decode
    always_comb begin
        cfg.swing_ok = 1'b1;
        case (cfg.swing)
            SW_600:  cfg.swing_mv = MV_600;
            SW_800:  cfg.swing_mv = MV_800;
            SW_1000: cfg.swing_mv = MV_1000;
            SW_1200: cfg.swing_mv = MV_1200;
            SW_1400: cfg.swing_mv = MV_1400;
            default: begin
                cfg.swing_mv = MV_600;
                cfg.swing_ok = 1'b0;
            end
        endcase
    end
endmodule : rlc_field_decode

// ===== hdl/rlc_strap_decode.sv
// Three-level strap pins to register codes
`timescale 1ns/10ps
module rlc_strap_decode
    import rlc_pkg::*;
(
    input  wire logic [1:0] deemph_strap_hi_i,
    input  wire logic [1:0] deemph_strap_lo_i,
    input  wire logic [1:0] equalizer_strap_a_i,
    input  wire logic [1:0] equalizer_strap_b_i,
    output logic      [7:0] de_code_o,
    output logic      [7:0] eq_code_o
);
    //////////////////////////////////////////////////////////////
    // Deemphasis strap table
    // strap to code
    always_comb begin
        case ({deemph_strap_hi_i, deemph_strap_lo_i})
            {LVL_0, LVL_0}: de_code_o = DE_0DB;
            {LVL_0, LVL_1}: de_code_o = DE_3P5;
            {LVL_0, LVL_F}: de_code_o = DE_6DB;
            {LVL_1, LVL_0}: de_code_o = DE_9DB;
            {LVL_1, LVL_1}: de_code_o = DE_12DB;
            {LVL_1, LVL_F}: de_code_o = DE_12DB;
            {LVL_F, LVL_0}: de_code_o = DE_9DB;
            {LVL_F, LVL_1}: de_code_o = DE_12DB;
            // All float and unknown levels are reserved
            default:        de_code_o = DE_RSVD;
        endcase
    end

    //////////////////////////////////////////////////////////////
    // Equalizer strap table
    // strap to code
    always_comb begin
        case ({equalizer_strap_a_i, equalizer_strap_b_i})
            {LVL_1, LVL_1}: eq_code_o = EQ_2A;
            {LVL_0, LVL_0}: eq_code_o = EQ_30;
            {LVL_0, LVL_F}: eq_code_o = EQ_31;
            {LVL_0, LVL_1}: eq_code_o = EQ_38;
            {LVL_1, LVL_F}: eq_code_o = EQ_34;
            {LVL_1, LVL_0}: eq_code_o = EQ_35;
            {LVL_F, LVL_0}: eq_code_o = EQ_3A;
            {LVL_F, LVL_1}: eq_code_o = EQ_3C;
            // All float means bypass
            default:        eq_code_o = EQ_BYP;
        endcase
    end
endmodule : rlc_strap_decode

// ===== hdl/rlc_top.sv
// Lane 6/7 configuration registers and settings outputs
`timescale 1ns/10ps
module rlc_top
    import rlc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        strap_mode_i,
    input  wire logic [1:0]  deemph_strap_hi_i,
    input  wire logic [1:0]  deemph_strap_lo_i,
    input  wire logic [1:0]  equalizer_strap_a_i,
    input  wire logic [1:0]  equalizer_strap_b_i,
    output logic      [7:0]  reg_rdata_o,
    output logic             reg_rvalid_o,
    output logic             lane6_deemphasis_style_o,
    output logic      [6:0]  lane6_out_deemphasis_o,
    output logic      [7:0]  lane6_deemph_tenths_o,
    output logic             lane6_deemph_ok_o,
    output logic      [7:0]  lane6_idle_deassert_mv_o,
    output logic      [7:0]  lane6_idle_assert_mv_o,
    output logic             lane7_idle_auto_o,
    output logic             lane7_squelch_o,
    output logic             lane7_signal_detect_en_o,
    output logic             lane7_rate_auto_o,
    output logic             lane7_rate_hi_o,
    output logic             lane7_eq_enable_o,
    output logic      [1:0]  lane7_gain_stage_o,
    output logic      [2:0]  lane7_boost_level_o,
    output logic      [10:0] lane7_out_swing_mv_o,
    output logic             lane7_swing_ok_o
);
    //////////////////////////////////////////////////////////////
    // Declarations
    logic [7:0] deemph_q, deemph_d;     // 3Ch
    logic [7:0] thr_q, thr_d;           // 3Dh
    logic [7:0] ir_q, ir_d;             // 40h
    logic [7:0] eq_q, eq_d;             // 41h
    logic [7:0] swing_q, swing_d;       // 42h
    logic       strap_pend_q;           // First cycle after reset
    logic [7:0] de_strap, eq_strap;     // Strap-derived codes
    logic [7:0] rdata_d;                // Read mux
    logic       sel_de, sel_thr, sel_ir, sel_eq, sel_sw;

    // One interface carries the raw fields so the bit split lives in one place
    rlc_cfg_if cfg ();

    rlc_strap_decode u_strap (
        .deemph_strap_hi_i   (deemph_strap_hi_i),
        .deemph_strap_lo_i   (deemph_strap_lo_i),
        .equalizer_strap_a_i (equalizer_strap_a_i),
        .equalizer_strap_b_i (equalizer_strap_b_i),
        .de_code_o           (de_strap),
        .eq_code_o           (eq_strap)
    );

    rlc_field_decode u_dec (
        .cfg (cfg)
    );

    assign cfg.deemph   = deemph_q;
    assign cfg.idle_thr = thr_q[3:0];
    assign cfg.swing    = swing_q[5:0];

    //////////////////////////////////////////////////////////////
    // Address decode
    assign sel_de  = (reg_addr_i == OFS_DEEMPH);
    assign sel_thr = (reg_addr_i == OFS_IDLE_THR);
    assign sel_ir  = (reg_addr_i == OFS_IDLE_RATE);
    assign sel_eq  = (reg_addr_i == OFS_EQ);
    assign sel_sw  = (reg_addr_i == OFS_SWING);

    //////////////////////////////////////////////////////////////
    // Register next values: host write beats strap load
    always_comb begin
        deemph_d = deemph_q;
        thr_d    = thr_q;
        ir_d     = ir_q;
        eq_d     = eq_q;
        swing_d  = swing_q;
        // Straps load once after reset in pin mode
        if (strap_pend_q && strap_mode_i) begin
            if (de_strap != DE_RSVD) begin
                deemph_d = de_strap;
            end
            eq_d = eq_strap;
        end
        if (reg_wr_i) begin
            if (sel_de) begin
                deemph_d = reg_wdata_i;
            end
            if (sel_thr) begin
                thr_d = reg_wdata_i;
            end
            if (sel_ir) begin
                ir_d = reg_wdata_i;
            end
            if (sel_eq) begin
                eq_d = reg_wdata_i;
            end
            // Upper swing bits are read-only zero
            if (sel_sw) begin
                swing_d = reg_wdata_i & SWING_WR_MASK;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            deemph_q     <= RST_DEEMPH;
            thr_q        <= RST_IDLE_THR;
            ir_q         <= RST_IDLE_RATE;
            eq_q         <= RST_EQ;
            swing_q      <= RST_SWING;
            strap_pend_q <= 1'b1;
        end else begin
            deemph_q     <= deemph_d;
            thr_q        <= thr_d;
            ir_q         <= ir_d;
            eq_q         <= eq_d;
            swing_q      <= swing_d;
            strap_pend_q <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////
    // Read mux; unmapped addresses read zero
    always_comb begin
        case (1'b1)
            sel_de:  rdata_d = deemph_q;
            sel_thr: rdata_d = thr_q;
            sel_ir:  rdata_d = ir_q;
            sel_eq:  rdata_d = eq_q;
            sel_sw:  rdata_d = swing_q;
            default: rdata_d = 8'h00;
        endcase
    end

    // Read data one cycle after the strobe
    // Idle data forced to zero so a stray sample never shows stale contents
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o  <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rdata_o  <= reg_rd_i ? rdata_d : 8'h00;
            reg_rvalid_o <= reg_rd_i;
        end
    end

    //////////////////////////////////////////////////////////////
    // Settings outputs, registered one cycle after the fields
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lane6_deemphasis_style_o <= 1'b0;
            lane6_out_deemphasis_o   <= 7'h00;
            lane6_deemph_tenths_o    <= 8'h00;
            lane6_deemph_ok_o        <= 1'b0;
            lane6_idle_deassert_mv_o <= 8'h00;
            lane6_idle_assert_mv_o   <= 8'h00;
            lane7_idle_auto_o        <= 1'b0;
            lane7_squelch_o          <= 1'b0;
            lane7_signal_detect_en_o <= 1'b0;
            lane7_rate_auto_o        <= 1'b0;
            lane7_rate_hi_o          <= 1'b0;
            lane7_eq_enable_o        <= 1'b0;
            lane7_gain_stage_o       <= 2'h0;
            lane7_boost_level_o      <= 3'h0;
            lane7_out_swing_mv_o     <= 11'h000;
            lane7_swing_ok_o         <= 1'b0;
        end else begin
            lane6_deemphasis_style_o <= deemph_q[DE_STYLE_BIT];
            lane6_out_deemphasis_o   <= deemph_q[6:0];
            lane6_deemph_tenths_o    <= cfg.de_tenths;
            lane6_deemph_ok_o        <= cfg.de_ok;
            lane6_idle_deassert_mv_o <= cfg.deas_mv;
            lane6_idle_assert_mv_o   <= cfg.as_mv;
            lane7_idle_auto_o        <= ir_q[IR_IDLE_AUTO];
            lane7_squelch_o          <= !ir_q[IR_IDLE_AUTO] && ir_q[IR_IDLE_SEL];
            lane7_signal_detect_en_o <= ir_q[IR_IDLE_AUTO];
            lane7_rate_auto_o        <= ir_q[IR_RATE_AUTO];
            lane7_rate_hi_o          <= !ir_q[IR_RATE_AUTO] && ir_q[IR_RATE_SEL];
            lane7_eq_enable_o        <= eq_q[EQ_EN_BIT];
            lane7_gain_stage_o       <= eq_q[4:3];
            lane7_boost_level_o      <= eq_q[2:0];
            lane7_out_swing_mv_o     <= cfg.swing_mv;
            lane7_swing_ok_o         <= cfg.swing_ok;
        end
    end

    //////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_style_from_write: assert property (
        reg_wr_i && sel_de |-> ##2
        lane6_deemphasis_style_o == $past(reg_wdata_i[7], 2))
        else $error("deemphasis style does not follow write");

    a_deemph_six_db: assert property (
        deemph_q == DE_6DB |=> lane6_deemph_tenths_o == 8'h3C && lane6_deemph_ok_o)
        else $error("code 88h not decoded as 6.0 dB");

    a_strap_rsvd_skip: assert property (
        strap_pend_q && strap_mode_i && !reg_wr_i && de_strap == DE_RSVD
        |=> deemph_q == RST_DEEMPH)
        else $error("reserved strap code loaded");

    a_thr_deassert_top: assert property (
        thr_q[3:2] == 2'h3 && thr_q[1:0] == 2'h0
        |=> lane6_idle_deassert_mv_o == 8'hBE && lane6_idle_assert_mv_o == 8'h46)
        else $error("threshold fields swapped or wrong");

    a_thr_default: assert property (
        thr_q[3:0] == 4'h0 |=> lane6_idle_deassert_mv_o == 8'h6E
        && lane6_idle_assert_mv_o == 8'h46)
        else $error("default idle threshold wrong");

    a_idle_auto_on: assert property (
        ir_q[5] |=> lane7_signal_detect_en_o && !lane7_squelch_o)
        else $error("auto idle not selected");

    a_idle_manual: assert property (
        !ir_q[5] |=> !lane7_signal_detect_en_o && lane7_squelch_o == $past(ir_q[4]))
        else $error("manual idle select ignored");

    a_rate_manual: assert property (
        !ir_q[1] |=> !lane7_rate_auto_o && lane7_rate_hi_o == $past(ir_q[0]))
        else $error("manual rate select ignored");

    a_rate_auto_low: assert property (
        ir_q[1] |=> lane7_rate_auto_o && !lane7_rate_hi_o)
        else $error("auto rate drives manual range");

    a_eq_fields: assert property (
        reg_wr_i && sel_eq |-> ##2 lane7_gain_stage_o == $past(reg_wdata_i[4:3], 2)
        && lane7_boost_level_o == $past(reg_wdata_i[2:0], 2))
        else $error("equalizer fields misplaced");

    a_eq_strap_float: assert property (
        strap_pend_q && strap_mode_i && !reg_wr_i && equalizer_strap_a_i == LVL_F
        && equalizer_strap_b_i == LVL_F |=> eq_q == 8'h20)
        else $error("float strap not bypass");

    a_swing_top: assert property (
        swing_q[5:0] == 6'h3F |=> lane7_out_swing_mv_o == 11'h578 && lane7_swing_ok_o)
        else $error("swing 3Fh not 1400 mV");

    a_reset_defaults: assert property (
        strap_pend_q && !strap_mode_i && !reg_wr_i
        |=> eq_q == 8'h20 && swing_q == 8'h03 && deemph_q == 8'h03)
        else $error("reset defaults lost");

    // Read port answers one cycle later and is zero when idle
    a_read_idle_zero: assert property (
        !reg_rd_i |=> !reg_rvalid_o && reg_rdata_o == 8'h00)
        else $error("read answer outside its cycle");

    a_unmapped_zero: assert property (
        reg_rd_i && !(sel_de || sel_thr || sel_ir || sel_eq || sel_sw)
        |=> reg_rvalid_o && reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");

    a_thr_write_lands: assert property (
        reg_wr_i && sel_thr |=> thr_q == $past(reg_wdata_i))
        else $error("threshold write did not land");

    a_ir_write_lands: assert property (
        reg_wr_i && sel_ir |=> ir_q == $past(reg_wdata_i))
        else $error("idle rate write did not land");

    a_swing_write_mask: assert property (
        reg_wr_i && sel_sw |=> swing_q == ($past(reg_wdata_i) & 8'h3F))
        else $error("swing write not masked");

    a_deemph_level: assert property (
        reg_wr_i && sel_de |-> ##2
        lane6_out_deemphasis_o == $past(reg_wdata_i[6:0], 2))
        else $error("deemphasis level does not follow write");

    a_eq_enable: assert property (
        reg_wr_i && sel_eq |-> ##2 lane7_eq_enable_o == $past(reg_wdata_i[5], 2))
        else $error("equalizer enable misplaced");

    c_write_then_read: cover property (
        reg_wr_i && sel_sw ##1 reg_rd_i && sel_sw ##1 reg_rvalid_o);
    c_manual_mute: cover property (!ir_q[5] && ir_q[4] ##1 lane7_squelch_o);
    c_strap_load: cover property (strap_pend_q && strap_mode_i ##1 eq_q != RST_EQ);
    c_reserved_strap: cover property (strap_pend_q && strap_mode_i && de_strap == DE_RSVD);
endmodule : rlc_top

// ===== pkg/rlc_cfg_if.sv
// Raw register codes out, decoded settings back
`timescale 1ns/10ps
interface rlc_cfg_if;
    logic [7:0]  deemph;     // Raw deemphasis code
    logic [3:0]  idle_thr;   // Raw threshold pair
    logic [5:0]  swing;      // Raw swing code
    logic [7:0]  de_tenths;  // Deemphasis magnitude
    logic        de_ok;      // Code is a listed level
    logic [7:0]  deas_mv;    // Idle deassert level
    logic [7:0]  as_mv;      // Idle assert level
    logic [10:0] swing_mv;   // Swing in mV
    logic        swing_ok;   // Code is a listed swing
    modport regs (output deemph, idle_thr, swing,
                  input de_tenths, de_ok, deas_mv, as_mv, swing_mv, swing_ok);
    modport dec  (input deemph, idle_thr, swing,
                  output de_tenths, de_ok, deas_mv, as_mv, swing_mv, swing_ok);
endinterface : rlc_cfg_if

// ===== pkg/rlc_pkg.sv
// Constants for the lane configuration register slice
package rlc_pkg;
    // Register offsets
    localparam logic [7:0] OFS_DEEMPH    = 8'h3C;
    localparam logic [7:0] OFS_IDLE_THR  = 8'h3D;
    localparam logic [7:0] OFS_IDLE_RATE = 8'h40;
    localparam logic [7:0] OFS_EQ        = 8'h41;
    localparam logic [7:0] OFS_SWING     = 8'h42;
    // Reset values
    localparam logic [7:0] RST_DEEMPH    = 8'h03;
    localparam logic [7:0] RST_IDLE_THR  = 8'h00;
    localparam logic [7:0] RST_IDLE_RATE = 8'h00;
    localparam logic [7:0] RST_EQ        = 8'h20;
    localparam logic [7:0] RST_SWING     = 8'h03;
    // Writable bits of the swing register
    localparam logic [7:0] SWING_WR_MASK = 8'h3F;
    // Field positions
    localparam int DE_STYLE_BIT  = 7;
    localparam int IR_IDLE_AUTO  = 5;
    localparam int IR_IDLE_SEL   = 4;
    localparam int IR_RATE_AUTO  = 1;
    localparam int IR_RATE_SEL   = 0;
    localparam int EQ_EN_BIT     = 5;
    // Three-level strap encodings
    localparam logic [1:0] LVL_0 = 2'h0;
    localparam logic [1:0] LVL_1 = 2'h1;
    localparam logic [1:0] LVL_F = 2'h2;
    // Deemphasis codes
    localparam logic [7:0] DE_0DB  = 8'h01;
    localparam logic [7:0] DE_3P5  = 8'h38;
    localparam logic [7:0] DE_6DB  = 8'h88;
    localparam logic [7:0] DE_9DB  = 8'h90;
    localparam logic [7:0] DE_12DB = 8'hA0;
    localparam logic [7:0] DE_RSVD = 8'hC0;
    // Deemphasis magnitudes in tenths of a dB
    localparam logic [7:0] DB_0   = 8'h00;
    localparam logic [7:0] DB_3P5 = 8'h23;
    localparam logic [7:0] DB_6   = 8'h3C;
    localparam logic [7:0] DB_9   = 8'h5A;
    localparam logic [7:0] DB_12  = 8'h78;
    // Equalizer codes
    localparam logic [7:0] EQ_BYP = 8'h20;
    localparam logic [7:0] EQ_2A  = 8'h2A;
    localparam logic [7:0] EQ_30  = 8'h30;
    localparam logic [7:0] EQ_31  = 8'h31;
    localparam logic [7:0] EQ_38  = 8'h38;
    localparam logic [7:0] EQ_34  = 8'h34;
    localparam logic [7:0] EQ_35  = 8'h35;
    localparam logic [7:0] EQ_3A  = 8'h3A;
    localparam logic [7:0] EQ_3C  = 8'h3C;
    // Swing codes and millivolts
    localparam logic [5:0]  SW_600  = 6'h03;
    localparam logic [5:0]  SW_800  = 6'h07;
    localparam logic [5:0]  SW_1000 = 6'h0F;
    localparam logic [5:0]  SW_1200 = 6'h1F;
    localparam logic [5:0]  SW_1400 = 6'h3F;
    localparam logic [10:0] MV_600  = 11'h258;
    localparam logic [10:0] MV_800  = 11'h320;
    localparam logic [10:0] MV_1000 = 11'h3E8;
    localparam logic [10:0] MV_1200 = 11'h4B0;
    localparam logic [10:0] MV_1400 = 11'h578;
    // Idle threshold millivolts
    localparam logic [7:0] MV_70  = 8'h46;
    localparam logic [7:0] MV_110 = 8'h6E;
    localparam logic [7:0] MV_130 = 8'h82;
    localparam logic [7:0] MV_150 = 8'h96;
    localparam logic [7:0] MV_170 = 8'hAA;
    localparam logic [7:0] MV_190 = 8'hBE;
endpackage : rlc_pkg

// ===== verif/repeater_lane_config_regs_bench.sv
// Self-checking bench for the lane configuration slice
`timescale 1ns/10ps
module repeater_lane_config_regs_bench;
    import rlc_pkg::*;
    logic        clk, rst_n, wr, rd, smode, rv, v, style, de_ok, i_auto, sq, sd_en;
    logic        r_auto, r_hi, eq_en, sw_ok;
    logic [7:0]  addr, wdata, rdata, d, de_t, th_d, th_a;
    logic [1:0]  s_hi, s_lo, s_a, s_b, gain_stage;
    logic [6:0]  de_lvl;
    logic [2:0]  boost_level;
    logic [10:0] sw_mv;
    int          err_count, compares, cyc;
    // Expected tables
    logic [7:0] deas_t[4] = '{MV_110, MV_150, MV_170, MV_190};
    logic [7:0] as_t[4]   = '{MV_70, MV_110, MV_130, MV_150};
    logic [7:0] de_c[6]   = '{8'h01, 8'h38, 8'h88, 8'h90, 8'hA0, 8'hC0};
    logic [7:0] sw_c[6]   = '{8'h03, 8'h07, 8'h0F, 8'h1F, 8'h3F, 8'h05};
    logic [7:0] de_s[9]   = '{8'h01, 8'h38, 8'h88, 8'h90, 8'hA0, 8'hA0, 8'h90, 8'hA0, 8'h03};
    logic [7:0] eq_s[9]   = '{8'h30, 8'h38, 8'h31, 8'h35, 8'h2A, 8'h34, 8'h3A, 8'h3C, 8'h20};
    ////////////////////////////////////////////////////////////////
    rlc_top dut_u (.clk_i(clk), .rst_n_i(rst_n), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .strap_mode_i(smode),
        .deemph_strap_hi_i(s_hi), .deemph_strap_lo_i(s_lo),
        .equalizer_strap_a_i(s_a), .equalizer_strap_b_i(s_b),
        .reg_rdata_o(rdata), .reg_rvalid_o(rv), .lane6_deemphasis_style_o(style),
        .lane6_out_deemphasis_o(de_lvl), .lane6_deemph_tenths_o(de_t),
        .lane6_deemph_ok_o(de_ok), .lane6_idle_deassert_mv_o(th_d),
        .lane6_idle_assert_mv_o(th_a), .lane7_idle_auto_o(i_auto), .lane7_squelch_o(sq),
        .lane7_signal_detect_en_o(sd_en), .lane7_rate_auto_o(r_auto),
        .lane7_rate_hi_o(r_hi), .lane7_eq_enable_o(eq_en), .lane7_gain_stage_o(gain_stage),
        .lane7_boost_level_o(boost_level), .lane7_out_swing_mv_o(sw_mv), .lane7_swing_ok_o(sw_ok));
    rlc_host_model u_host (.clk_i(clk), .reg_rdata_i(rdata), .reg_rvalid_i(rv),
        .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr), .reg_wdata_o(wdata));
    // Free-running 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Hang guard, far above the expected run
    always @(posedge clk) begin
        cyc++;
        if (cyc >= 5000) begin
            err_count++;
            complete_run();
        end
    end
    // Deemphasis code to {listed, tenths of dB}
    function automatic logic [8:0] de_exp(input logic [7:0] c);
        case (c)
            DE_0DB:  de_exp = {1'b1, DB_0};
            DE_3P5:  de_exp = {1'b1, DB_3P5};
            DE_6DB:  de_exp = {1'b1, DB_6};
            DE_9DB:  de_exp = {1'b1, DB_9};
            DE_12DB: de_exp = {1'b1, DB_12};
            default: de_exp = 9'h000;
        endcase
    endfunction : de_exp
    // Swing code to {listed, mV}; unlisted falls back to 600
    function automatic logic [11:0] sw_exp(input logic [5:0] c);
        case (c)
            SW_600:  sw_exp = {1'b1, MV_600};
            SW_800:  sw_exp = {1'b1, MV_800};
            SW_1000: sw_exp = {1'b1, MV_1000};
            SW_1200: sw_exp = {1'b1, MV_1200};
            SW_1400: sw_exp = {1'b1, MV_1400};
            default: sw_exp = {1'b0, MV_600};
        endcase
    endfunction : sw_exp
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // Read and compare, valid flag included
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        u_host.read_reg(a, d, v);
        chk(16'(v), 16'h0001);
        chk(16'(d), 16'(e));
    endtask : rchk
    // Write, then let the settings update land
    task automatic wset(input logic [7:0] a, input logic [7:0] x);
        u_host.write_reg(a, x);
        @(negedge clk);
    endtask : wset
    // Reset held 10 cycles; strap mode seen at the first edge
    task automatic do_reset(input logic m);
        @(negedge clk);
        rst_n = 1'b0;
        smode = m;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        smode = 1'b0;
    endtask : do_reset
    task automatic note(input string s);
        $display("test %s done", s);
    endtask : note
    task automatic complete_run;
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        smode = 1'b0;
        {s_hi, s_lo, s_a, s_b} = 8'h00;
        void'($urandom(42));
        do_reset(1'b0);
        // Defaults and their decoded settings
        rchk(OFS_DEEMPH, RST_DEEMPH);
        rchk(OFS_IDLE_THR, RST_IDLE_THR);
        rchk(OFS_IDLE_RATE, RST_IDLE_RATE);
        rchk(OFS_EQ, RST_EQ);
        rchk(OFS_SWING, RST_SWING);
        chk({de_ok, eq_en, th_d, th_a}, {2'b01, MV_110, MV_70});
        rchk(8'h3E, 8'h00);
        note("reset");
        // Every listed deemphasis code plus the reserved one
        foreach (de_c[i]) begin
            wset(OFS_DEEMPH, de_c[i]);
            chk({de_ok, de_t}, de_exp(de_c[i]));
            chk({style, de_lvl}, de_c[i]);
        end
        note("deemph");
        // All threshold pairs and all idle/rate mode combinations
        for (int i = 0; i < 16; i++) begin
            wset(OFS_IDLE_THR, 8'(i));
            chk({th_d, th_a}, {deas_t[i[3:2]], as_t[i[1:0]]});
            wset(OFS_IDLE_RATE, {2'b00, i[3:2], 2'b00, i[1:0]});
            chk({i_auto, sq, sd_en}, {i[3], !i[3] && i[2], i[3]});
            chk({r_auto, r_hi}, {i[1], !i[1] && i[0]});
        end
        rchk(OFS_IDLE_THR, 8'h0F);
        note("idle_rate");
        // Swing codes, one unlisted
        foreach (sw_c[i]) begin
            wset(OFS_SWING, sw_c[i]);
            chk({sw_ok, sw_mv}, sw_exp(sw_c[i][5:0]));
        end
        rchk(OFS_SWING, 8'h05);
        note("swing");
        // Random equalizer settings
        repeat (20) begin
            d = 8'($urandom()) & 8'h3F;
            wset(OFS_EQ, d);
            chk({eq_en, gain_stage, boost_level}, d[5:0]);
            rchk(OFS_EQ, d);
        end
        note("equalizer");
        // Every strap level pair through a reset
        for (int i = 0; i < 9; i++) begin
            s_hi = 2'(i / 3);
            s_lo = 2'(i % 3);
            s_a  = s_hi;
            s_b  = s_lo;
            do_reset(1'b1);
            rchk(OFS_DEEMPH, de_s[i]);
            rchk(OFS_EQ, eq_s[i]);
        end
        note("straps");
        complete_run();
    end
endmodule : repeater_lane_config_regs_bench

// ===== verif/rlc_host_model.sv
// Host controller model driving the register port
`timescale 1ns/10ps
module rlc_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] reg_rdata_i,
    input  wire logic       reg_rvalid_i,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic      [7:0] reg_addr_o,
    output logic      [7:0] reg_wdata_o
);
    // Quiet port from time zero
    initial begin
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
    end
    function automatic logic [7:0] wmask(input logic [7:0] a);
        case (a)
            8'h3D:        wmask = 8'h0F;
            8'h40:        wmask = 8'h33;
            8'h41, 8'h42: wmask = 8'h3F;
            default:      wmask = 8'hFF;
        endcase
    endfunction : wmask
    // One write; released lines show the inverse, not the last value
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        reg_wr_o    = 1'b1;
        reg_addr_o  = a;
        reg_wdata_o = d & wmask(a);
        @(negedge clk_i);
        reg_wr_o    = 1'b0;
        reg_addr_o  = ~a;
        reg_wdata_o = ~reg_wdata_o;
    endtask : write_reg
    // One read; answer sampled while it stands
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge clk_i);
        reg_rd_o   = 1'b1;
        reg_addr_o = a;
        @(negedge clk_i);
        reg_rd_o   = 1'b0;
        reg_addr_o = ~a;
        d = reg_rdata_i;
        v = reg_rvalid_i;
    endtask : read_reg
endmodule : rlc_host_model
